// ### timer16_counter_input_capture.sv
`timescale 1ns/1ps
// Functional notes
// - Tick source zero stops the counter
// - Counter seen as low and high bytes
// - Low read/write moves high byte via holding
// - Tick clears or steps counter by mode
// - Processor counter write beats counting
// - Counter accessible even when stopped
// - Four mode bits across control A and B
// - Overflow flag set per mode, irq source
// - Matching edge copies counter into capture
// - Capture flag set with the copy
// - Enabled flag requests irq, ack clears it
// - Writing one clears the capture flag
// - Capture low read loads holding register
// - Capture writable only in capture-ceiling modes
// - Comparator select replaces pin as trigger
// - Source switch may capture; software clears
// - Inputs synchronised; filter adds four cycles
// - No capture in capture-ceiling modes
// - Filter output changes after four equal samples
// - Filter runs on undivided system clock
// - New capture overwrites unread value
// - Driving the pin itself triggers capture
// - Floor output when counter is zero
// - Ceiling fixed, compare A or capture
module timer16_counter_input_capture (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst,
   input  wire timer16_pkg::cpu_req_t i_bus,
   output logic [7:0]                 o_rdata,
   input  wire logic [3:0]            i_prescale_ticks,
   input  wire logic                  i_external_count_pin,
   input  wire logic                  i_capture_pin,
   input  wire logic                  i_comparator_output,
   input  wire logic [15:0]           i_compare_a,
   input  wire logic                  i_capture_irq_ack,
   input  wire logic                  i_overflow_irq_ack,
   output logic                       o_capture_irq,
   output logic                       o_overflow_irq,
   output logic [15:0]                o_count_value,
   output logic                       o_count_floor,
   output logic                       o_count_ceiling
);

   // ----------------------------------------------------------------
   // Mode decoding
   // ----------------------------------------------------------------
   function automatic logic mode_uses_capture_top(input logic [3:0] m);
      return (m == 4'h8) || (m == 4'ha) || (m == 4'hc) || (m == 4'he);
   endfunction

   function automatic logic mode_dual_slope(input logic [3:0] m);
      return (m == 4'h1) || (m == 4'h2) || (m == 4'h3) ||
             (m == 4'h8) || (m == 4'h9) || (m == 4'ha) || (m == 4'hb);
   endfunction

   function automatic logic [15:0] mode_top(input logic [3:0]  m,
                                            input logic [15:0] ocra,
                                            input logic [15:0] icr);
      logic [15:0] t;
      t = timer16_pkg::COUNT_MAX;
      if ((m == 4'h1) || (m == 4'h5)) begin
         t = timer16_pkg::TOP_8BIT;
      end else if ((m == 4'h2) || (m == 4'h6)) begin
         t = timer16_pkg::TOP_9BIT;
      end else if ((m == 4'h3) || (m == 4'h7)) begin
         t = timer16_pkg::TOP_10BIT;
      end else if ((m == 4'h4) || (m == 4'h9) || (m == 4'hb) || (m == 4'hf)) begin
         t = ocra;
      end else if (mode_uses_capture_top(m)) begin
         t = icr;
      end
      return t;
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  ctrl_a_q, ctrl_b_q, irq_en_q, comp_ctrl_q, temp_q, rdata_q;
   logic [15:0] cnt_q, cnt_d, cap_q;
   logic        dir_down_q, dir_down_d;
   logic        cap_flag_q, ovf_flag_q;
   logic [1:0]  ext_sync_q, pin_sync_q, comp_sync_q;
   logic        ext_prev_q, edge_prev_q;

   timer16_pkg::timer_cfg_t cfg;
   assign cfg.tick_source_select = ctrl_b_q[timer16_pkg::TB_TICK_LSB +: 3];
   assign cfg.waveform_mode_bits = {ctrl_b_q[timer16_pkg::TB_WGM_HI_LSB +: 2],
                                    ctrl_a_q[timer16_pkg::TA_WGM_LO_LSB +: 2]};
   assign cfg.edge_rising               = ctrl_b_q[timer16_pkg::TB_EDGE_BIT];
   assign cfg.noise_filter_enable       = ctrl_b_q[timer16_pkg::TB_FILTER_BIT];
   assign cfg.comparator_capture_select = comp_ctrl_q[timer16_pkg::COMP_CAPSEL_BIT];

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic sel_cl = i_bus.sel == timer16_pkg::SEL_COUNT_LOW;
   wire logic sel_ch = i_bus.sel == timer16_pkg::SEL_COUNT_HIGH;
   wire logic sel_pl = i_bus.sel == timer16_pkg::SEL_CAPTURE_LOW;
   wire logic sel_ph = i_bus.sel == timer16_pkg::SEL_CAPTURE_HIGH;
   wire logic sel_fl = i_bus.sel == timer16_pkg::SEL_FLAGS;

   wire logic cnt_wr     = i_bus.wr && sel_cl;
   wire logic icr_top    = mode_uses_capture_top(cfg.waveform_mode_bits);
   wire logic cap_wr     = i_bus.wr && sel_pl && icr_top;
   wire logic temp_wr    = i_bus.wr && (sel_ch || sel_ph);
   wire logic cap_clr    = i_bus.wr && sel_fl && i_bus.wdata[timer16_pkg::FLAG_CAP_BIT];
   wire logic ovf_clr    = i_bus.wr && sel_fl && i_bus.wdata[timer16_pkg::FLAG_OVF_BIT];

   wire logic [7:0] flags_rd = (8'(cap_flag_q) << timer16_pkg::FLAG_CAP_BIT) |
                               (8'(ovf_flag_q) << timer16_pkg::FLAG_OVF_BIT);
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (i_bus.sel)
         timer16_pkg::SEL_COUNT_LOW:    rd_mux = cnt_q[7:0];
         timer16_pkg::SEL_COUNT_HIGH:   rd_mux = temp_q;
         timer16_pkg::SEL_CAPTURE_LOW:  rd_mux = cap_q[7:0];
         timer16_pkg::SEL_CAPTURE_HIGH: rd_mux = temp_q;
         timer16_pkg::SEL_TIMER_CTRL_A: rd_mux = ctrl_a_q;
         timer16_pkg::SEL_TIMER_CTRL_B: rd_mux = ctrl_b_q;
         timer16_pkg::SEL_FLAGS:        rd_mux = flags_rd;
         timer16_pkg::SEL_IRQ_ENABLE:   rd_mux = irq_en_q;
         timer16_pkg::SEL_COMP_CTRL:    rd_mux = comp_ctrl_q;
         default:                       rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // Tick selection
   // ----------------------------------------------------------------
   wire logic ext_rise = ext_sync_q[1] && !ext_prev_q;
   wire logic ext_fall = !ext_sync_q[1] && ext_prev_q;
   logic tick;
   always_comb begin
      tick = 1'b0;
      unique case (cfg.tick_source_select)
         3'h0: tick = 1'b0;
         3'h1: tick = 1'b1;
         3'h2: tick = i_prescale_ticks[0];
         3'h3: tick = i_prescale_ticks[1];
         3'h4: tick = i_prescale_ticks[2];
         3'h5: tick = i_prescale_ticks[3];
         3'h6: tick = ext_fall;
         3'h7: tick = ext_rise;
      endcase
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   wire logic [15:0] top      = mode_top(cfg.waveform_mode_bits, i_compare_a, cap_q);
   wire logic        at_top   = cnt_q == top;
   wire logic        at_floor = cnt_q == timer16_pkg::COUNT_FLOOR;
   wire logic        dual     = mode_dual_slope(cfg.waveform_mode_bits);
   // Overflow in dual slope is at the floor, elsewhere at the ceiling
   wire logic ovf_evt = tick && !cnt_wr && (dual ? (dir_down_q && at_floor) : at_top);

   always_comb begin
      cnt_d      = cnt_q;
      dir_down_d = dir_down_q;
      if (cnt_wr) begin
         cnt_d = {temp_q, i_bus.wdata};
      end else if (tick) begin
         if (!dual) begin
            cnt_d = at_top ? timer16_pkg::COUNT_FLOOR : cnt_q + timer16_pkg::COUNT_STEP;
         end else if (dir_down_q) begin
            dir_down_d = !at_floor;
            cnt_d = at_floor ? cnt_q + timer16_pkg::COUNT_STEP : cnt_q - timer16_pkg::COUNT_STEP;
         end else begin
            dir_down_d = at_top;
            cnt_d = at_top ? cnt_q - timer16_pkg::COUNT_STEP : cnt_q + timer16_pkg::COUNT_STEP;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture path
   // ----------------------------------------------------------------
   // Mux after the synchronisers: a source switch can look like an edge
   wire logic src_level = cfg.comparator_capture_select ? comp_sync_q[1]
                                                        : pin_sync_q[1];
   logic filt_level;
   capture_noise_filter u_filter (
      .i_clk    (i_clk),
      .i_rst    (i_rst),
      .i_enable (cfg.noise_filter_enable),
      .i_level  (src_level),
      .o_level  (filt_level)
   );
   wire logic edge_hit = cfg.edge_rising ? (filt_level && !edge_prev_q)
                                         : (!filt_level && edge_prev_q);
   wire logic cap_trig = edge_hit && !icr_top;

   // ----------------------------------------------------------------
   // Sequential state
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ext_sync_q  <= 2'h0;
         pin_sync_q  <= 2'h0;
         comp_sync_q <= 2'h0;
         ext_prev_q  <= 1'b0;
         edge_prev_q <= 1'b0;
      end else begin
         ext_sync_q  <= {ext_sync_q[0], i_external_count_pin};
         pin_sync_q  <= {pin_sync_q[0], i_capture_pin};
         comp_sync_q <= {comp_sync_q[0], i_comparator_output};
         ext_prev_q  <= ext_sync_q[1];
         edge_prev_q <= filt_level;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_q      <= timer16_pkg::RST_WORD;
         dir_down_q <= 1'b0;
         cap_q      <= timer16_pkg::RST_WORD;
      end else begin
         cnt_q      <= cnt_d;
         dir_down_q <= dir_down_d;
         if (cap_trig) begin
            cap_q <= cnt_q;
         end else if (cap_wr) begin
            cap_q <= {temp_q, i_bus.wdata};
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         temp_q <= timer16_pkg::RST_BYTE;
      end else if (temp_wr) begin
         temp_q <= i_bus.wdata;
      end else if (i_bus.rd && sel_cl) begin
         temp_q <= cnt_q[15:8];
      end else if (i_bus.rd && sel_pl) begin
         temp_q <= cap_q[15:8];
      end
   end

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cap_flag_q <= 1'b0;
         ovf_flag_q <= 1'b0;
      end else begin
         cap_flag_q <= cap_trig ||
                       (cap_flag_q && !cap_clr && !i_capture_irq_ack);
         ovf_flag_q <= ovf_evt || (ovf_flag_q && !ovf_clr && !i_overflow_irq_ack);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_a_q    <= timer16_pkg::RST_BYTE;
         ctrl_b_q    <= timer16_pkg::RST_BYTE;
         irq_en_q    <= timer16_pkg::RST_BYTE;
         comp_ctrl_q <= timer16_pkg::RST_BYTE;
         rdata_q     <= timer16_pkg::RST_BYTE;
      end else begin
         if (i_bus.wr && i_bus.sel == timer16_pkg::SEL_TIMER_CTRL_A) ctrl_a_q <= i_bus.wdata;
         if (i_bus.wr && i_bus.sel == timer16_pkg::SEL_TIMER_CTRL_B) ctrl_b_q <= i_bus.wdata;
         if (i_bus.wr && i_bus.sel == timer16_pkg::SEL_IRQ_ENABLE) irq_en_q <= i_bus.wdata;
         if (i_bus.wr && i_bus.sel == timer16_pkg::SEL_COMP_CTRL) comp_ctrl_q <= i_bus.wdata;
         if (i_bus.rd) rdata_q <= rd_mux;
      end
   end

   assign o_rdata         = rdata_q;
   assign o_count_value   = cnt_q;
   assign o_count_floor   = at_floor;
   assign o_count_ceiling = at_top;
   assign o_capture_irq   = cap_flag_q && irq_en_q[timer16_pkg::FLAG_CAP_BIT];
   assign o_overflow_irq  = ovf_flag_q && irq_en_q[timer16_pkg::FLAG_OVF_BIT];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_stopped_holds: assert property (
      (cfg.tick_source_select == 3'h0) && !cnt_wr |=> $stable(cnt_q))
      else $error("counter moved with no tick source");
   a_low_read_temp: assert property (
      i_bus.rd && sel_cl && !temp_wr |=> temp_q == $past(cnt_q[15:8]))
      else $error("holding register missed counter high byte");
   a_write_wins: assert property (
      cnt_wr |=> cnt_q == {$past(temp_q), $past(i_bus.wdata)})
      else $error("counter write lost");
   a_step_up: assert property (
      tick && !cnt_wr && !dual && !at_top |=> cnt_q == $past(cnt_q) + 16'h0001)
      else $error("counter did not step up");
   a_step_down: assert property (
      tick && !cnt_wr && dual && dir_down_q && !at_floor |=> cnt_q == $past(cnt_q) - 16'h0001)
      else $error("counter did not step down");
   a_turn_top: assert property (
      tick && !cnt_wr && dual && !dir_down_q && at_top
      |=> dir_down_q && (cnt_q == $past(cnt_q) - 16'h0001))
      else $error("counter did not turn at the ceiling");
   a_overflow_set: assert property (
      tick && !cnt_wr && !dual && at_top |=> ovf_flag_q && (cnt_q == timer16_pkg::COUNT_FLOOR))
      else $error("no wrap or overflow flag at the ceiling");
   a_ovf_ack_clear: assert property (
      i_overflow_irq_ack && !ovf_evt |=> !ovf_flag_q)
      else $error("overflow flag not cleared by ack");
   a_capture_copy: assert property (
      cap_trig |=> (cap_q == $past(cnt_q)) && cap_flag_q)
      else $error("capture copy or flag wrong");
   a_pin_latency: assert property (
      $rose(pin_sync_q[1]) && $stable(ctrl_b_q) && $stable(comp_ctrl_q) && cfg.edge_rising &&
      !cfg.comparator_capture_select && !cfg.noise_filter_enable && !icr_top
      |=> cap_flag_q && (cap_q == $past(cnt_q)))
      else $error("capture not one edge after the synchronised pin");
   a_flag_clear: assert property (
      cap_flag_q && cap_clr && !cap_trig |=> !cap_flag_q)
      else $error("capture flag not cleared");
   a_ack_clear: assert property (
      i_capture_irq_ack && !cap_trig ##1 !cap_trig |-> !cap_flag_q)
      else $error("capture flag not cleared by ack");
   a_irq_gate: assert property (
      cap_trig && irq_en_q[timer16_pkg::FLAG_CAP_BIT] &&
      !(i_bus.wr && (i_bus.sel == timer16_pkg::SEL_IRQ_ENABLE)) |=> o_capture_irq)
      else $error("enabled capture raised no irq");
   a_cap_read_temp: assert property (
      i_bus.rd && sel_pl && !temp_wr |=> temp_q == $past(cap_q[15:8]))
      else $error("holding register missed capture high byte");
   a_high_read: assert property (
      i_bus.rd && (sel_ch || sel_ph) |=> o_rdata == $past(temp_q))
      else $error("high byte read bypassed the holding register");
   a_rdata_hold: assert property (
      !i_bus.rd |=> $stable(o_rdata))
      else $error("read data moved without a read");
   a_cap_write_gate: assert property (
      i_bus.wr && sel_pl && !icr_top && !cap_trig |=> $stable(cap_q))
      else $error("capture written outside ceiling mode");
   a_cap_wr_lands: assert property (
      cap_wr && !cap_trig |=> cap_q == {$past(temp_q), $past(i_bus.wdata)})
      else $error("capture ceiling write lost");
   a_no_capture_icr: assert property (
      icr_top && !cap_wr && !cap_flag_q |=> $stable(cap_q) && !cap_flag_q)
      else $error("capture in capture-ceiling mode");
   a_reset_zero: assert property (
      $fell(i_rst) |-> (cnt_q == timer16_pkg::RST_WORD) && (cap_q == timer16_pkg::RST_WORD) &&
      (temp_q == timer16_pkg::RST_BYTE) && !cap_flag_q)
      else $error("state not zero after reset");

   c_capture: cover property (cap_trig ##1 o_capture_irq);
   c_filtered_capture: cover property (cfg.noise_filter_enable && cap_trig);
   c_overflow: cover property (ovf_evt ##1 ovf_flag_q);
   c_write_on_tick: cover property (cnt_wr && tick);

endmodule

// ### timer16_pkg.sv
package timer16_pkg;

   // ----------------------------------------------------------------
   // Register selects on the byte bus
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_COUNT_LOW     = 4'h0;
   localparam logic [3:0] SEL_COUNT_HIGH    = 4'h1;
   localparam logic [3:0] SEL_CAPTURE_LOW   = 4'h2;
   localparam logic [3:0] SEL_CAPTURE_HIGH  = 4'h3;
   localparam logic [3:0] SEL_TIMER_CTRL_A  = 4'h4;
   localparam logic [3:0] SEL_TIMER_CTRL_B  = 4'h5;
   localparam logic [3:0] SEL_FLAGS         = 4'h6;
   localparam logic [3:0] SEL_IRQ_ENABLE    = 4'h7;
   localparam logic [3:0] SEL_COMP_CTRL     = 4'h8;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int TB_TICK_LSB     = 0;
   localparam int TB_WGM_HI_LSB   = 3;
   localparam int TB_EDGE_BIT     = 6;
   localparam int TB_FILTER_BIT   = 7;
   localparam int TA_WGM_LO_LSB   = 0;
   localparam int FLAG_OVF_BIT    = 0;
   localparam int FLAG_CAP_BIT    = 5;
   localparam int COMP_CAPSEL_BIT = 2;

   // ----------------------------------------------------------------
   // Reset values and fixed counter values
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE     = 8'h00;
   localparam logic [15:0] RST_WORD     = 16'h0000;
   localparam logic [15:0] COUNT_FLOOR  = 16'h0000;
   localparam logic [15:0] COUNT_MAX    = 16'hffff;
   localparam logic [15:0] TOP_8BIT     = 16'h00ff;
   localparam logic [15:0] TOP_9BIT     = 16'h01ff;
   localparam logic [15:0] TOP_10BIT    = 16'h03ff;
   localparam logic [15:0] COUNT_STEP   = 16'h0001;
   localparam int          FILTER_DEPTH = 4;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [3:0] sel;
      logic [7:0] wdata;
   } cpu_req_t;

   typedef struct packed {
      logic [2:0] tick_source_select;
      logic [3:0] waveform_mode_bits;
      logic       edge_rising;
      logic       noise_filter_enable;
      logic       comparator_capture_select;
   } timer_cfg_t;

endpackage

// ### capture_noise_filter.sv
`timescale 1ns/1ps
module capture_noise_filter (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_enable,
   input  wire logic i_level,
   output logic      o_level
);

   logic [timer16_pkg::FILTER_DEPTH-2:0] hist_q;
   logic                                 out_q;
   wire logic [timer16_pkg::FILTER_DEPTH-1:0] window = {hist_q, i_level};
   wire logic all_high = &window;
   wire logic all_low  = ~|window;

   // Samples on every system clock, so prescaling never stretches it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hist_q <= '0;
         out_q  <= 1'b0;
      end else begin
         hist_q <= {hist_q[timer16_pkg::FILTER_DEPTH-3:0], i_level};
         if (all_high || all_low) begin
            out_q <= i_level;
         end
      end
   end

   // Bypass is combinational so the filter adds exactly four cycles
   assign o_level = i_enable ? out_q : i_level;

endmodule

// ### cpu_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor side of the byte bus
// ----------------------------------------------------------------
module cpu_bus_model (
   input  wire logic             i_clk,
   input  wire logic [7:0]       i_rdata,
   output timer16_pkg::cpu_req_t o_bus
);
   initial o_bus = '0;
   // An idle edge leads every access, so a strobe is never set twice in one step
   task automatic access(input logic r, input logic w, input logic [3:0] s,
                         input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      #1;
      o_bus = '{rd: r, wr: w, sel: s, wdata: d};
      @(posedge i_clk);
      #1;
      q = i_rdata;
      o_bus = '0;
   endtask
   task automatic wr8(input logic [3:0] s, input logic [7:0] d);
      logic [7:0] q;
      access(1'b0, 1'b1, s, d, q);
   endtask
   task automatic rd8(input logic [3:0] s, output logic [7:0] q);
      access(1'b1, 1'b0, s, 8'h00, q);
   endtask
   // High byte first: the low write commits holding and low together
   task automatic wr16(input logic [3:0] s, input logic [15:0] d);
      wr8(s + 4'h1, d[15:8]);
      wr8(s, d[7:0]);
   endtask
   // Low byte first: it snapshots the high byte into holding
   task automatic rd16(input logic [3:0] s, output logic [15:0] q);
      rd8(s, q[7:0]);
      rd8(s + 4'h1, q[15:8]);
   endtask
   task automatic clr_cap();
      wr8(timer16_pkg::SEL_FLAGS, 8'h20);
   endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   timer16_pkg::cpu_req_t bus;
   logic [7:0]            rdata;
   logic                  cap_pin = 1'b0;
   logic                  comp = 1'b0;
   logic                  cap_ack = 1'b0;
   logic                  ovf_ack = 1'b0;
   logic                  ext_pin = 1'b0;
   logic [3:0]            pre = 4'h0;
   logic                  cap_irq;
   logic                  ovf_irq;
   logic [15:0]           count;
   logic                  floor_s;
   logic                  ceil_s;
   logic [15:0]           v;
   int                    n_errors = 0;
   int                    cmp_count = 0;
   logic [3:0]            modes [6] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h4, 4'hc};
   logic [15:0]           tops [6] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff,
                                       16'h0123, 16'h0456};
   always #50 clk = ~clk;
   timer16_counter_input_capture u_timer16_counter_input_capture (
      .i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata),
      .i_prescale_ticks(pre), .i_external_count_pin(ext_pin),
      .i_capture_pin(cap_pin), .i_comparator_output(comp),
      .i_compare_a(16'h0123), .i_capture_irq_ack(cap_ack),
      .i_overflow_irq_ack(ovf_ack), .o_capture_irq(cap_irq),
      .o_overflow_irq(ovf_irq), .o_count_value(count),
      .o_count_floor(floor_s), .o_count_ceiling(ceil_s));
   cpu_bus_model u_cpu_bus_model (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic set_mode(input logic [3:0] m, input logic [2:0] t,
                           input logic e, input logic f);
      u_cpu_bus_model.wr8(timer16_pkg::SEL_TIMER_CTRL_A, {6'h00, m[1:0]});
      u_cpu_bus_model.wr8(timer16_pkg::SEL_TIMER_CTRL_B, {f, e, 1'b0, m[3:2], t});
   endtask
   task automatic rdcap(input logic [15:0] exp);
      u_cpu_bus_model.rd16(timer16_pkg::SEL_CAPTURE_LOW, v);
      check(v, exp);
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      cyc(6);
      rst = 1'b0;
      check(16'(floor_s), 16'h0001);
      u_cpu_bus_model.rd16(timer16_pkg::SEL_COUNT_LOW, v);
      check(v, 16'h0000);
      // Capture low write is refused outside capture-ceiling modes
      u_cpu_bus_model.wr16(timer16_pkg::SEL_CAPTURE_LOW, 16'h5555);
      rdcap(16'h0000);
      u_cpu_bus_model.wr8(timer16_pkg::SEL_IRQ_ENABLE, 8'h21);
      set_mode(4'h0, 3'h1, 1'b1, 1'b0);
      v = count;
      cyc(5);
      check(count, v + 16'h0005);
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'hfffe);
      check(count, 16'hfffe);
      cyc(1);
      check(16'(ovf_irq), 16'h0000);
      cyc(1);
      check(count, 16'h0000);
      check(16'(ovf_irq), 16'h0001);
      set_mode(4'h0, 3'h0, 1'b1, 1'b0);
      ovf_ack = 1'b1;
      cyc(1);
      ovf_ack = 1'b0;
      check(16'(ovf_irq), 16'h0000);
      v = count;
      cyc(4);
      check(count, v);
      // External pin edges and one prescaler pulse each give one tick
      set_mode(4'h0, 3'h7, 1'b1, 1'b0);
      v = count;
      ext_pin = 1'b1;
      cyc(6);
      check(count, v + 16'h0001);
      set_mode(4'h0, 3'h6, 1'b1, 1'b0);
      ext_pin = 1'b0;
      cyc(6);
      check(count, v + 16'h0002);
      set_mode(4'h0, 3'h2, 1'b1, 1'b0);
      pre = 4'h1;
      cyc(1);
      pre = 4'h0;
      cyc(2);
      check(count, v + 16'h0003);
      // Dual slope turns at the ceiling and steps back down
      set_mode(4'h1, 3'h1, 1'b1, 1'b0);
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'h00fd);
      cyc(4);
      check(count, 16'h00fd);
      set_mode(4'h0, 3'h0, 1'b1, 1'b0);
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'h1234);
      u_cpu_bus_model.rd16(timer16_pkg::SEL_COUNT_LOW, v);
      check(v, 16'h1234);
      // Pin rise: two sync stages plus the edge stage
      cap_pin = 1'b1;
      cyc(2);
      check(16'(cap_irq), 16'h0000);
      cyc(1);
      check(16'(cap_irq), 16'h0001);
      rdcap(16'h1234);
      cap_ack = 1'b1;
      cyc(1);
      cap_ack = 1'b0;
      check(16'(cap_irq), 16'h0000);
      cap_pin = 1'b0;
      cyc(8);
      check(16'(cap_irq), 16'h0000);
      set_mode(4'h0, 3'h0, 1'b0, 1'b1);
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'h2222);
      // A three-sample glitch must not pass the filter
      cap_pin = 1'b1;
      cyc(3);
      cap_pin = 1'b0;
      cyc(10);
      check(16'(cap_irq), 16'h0000);
      cap_pin = 1'b1;
      cyc(10);
      cap_pin = 1'b0;
      cyc(6);
      check(16'(cap_irq), 16'h0000);
      cyc(1);
      check(16'(cap_irq), 16'h0001);
      u_cpu_bus_model.clr_cap();
      check(16'(cap_irq), 16'h0000);
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'h3333);
      cap_pin = 1'b1;
      cyc(10);
      cap_pin = 1'b0;
      cyc(10);
      rdcap(16'h3333);
      set_mode(4'h0, 3'h0, 1'b1, 1'b0);
      u_cpu_bus_model.wr8(timer16_pkg::SEL_COMP_CTRL, 8'h04);
      u_cpu_bus_model.clr_cap();
      u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, 16'h4444);
      cap_pin = 1'b1;
      cyc(8);
      check(16'(cap_irq), 16'h0000);
      comp = 1'b1;
      cyc(3);
      check(16'(cap_irq), 16'h0001);
      rdcap(16'h4444);
      // Ceiling per mode, mode bits split over both control registers
      for (int i = 0; i < 6; i++) begin
         set_mode(modes[i], 3'h0, 1'b1, 1'b0);
         if (modes[i] == 4'hc) begin
            u_cpu_bus_model.wr16(timer16_pkg::SEL_CAPTURE_LOW, 16'h0456);
            rdcap(16'h0456);
         end
         u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, tops[i]);
         check(16'(ceil_s), 16'h0001);
         check(16'(floor_s), 16'h0000);
         u_cpu_bus_model.wr16(timer16_pkg::SEL_COUNT_LOW, tops[i] - 16'h0001);
         check(16'(ceil_s), 16'h0000);
      end
      u_cpu_bus_model.clr_cap();
      comp = 1'b0;
      cyc(8);
      comp = 1'b1;
      cyc(8);
      check(16'(cap_irq), 16'h0000);
      rdcap(16'h0456);
      tally_and_finish();
   end
   // Whole run is a few hundred cycles; this allows ten thousand
   initial begin
      #1000000;
      n_errors++;
      tally_and_finish();
   end
endmodule
